// ===== hdl/tsc_top.sv
module tsc_top (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic standby_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic [2:0] count_tick_in,
    input wire logic [2:0] count_down_in,
    input wire logic [2:0] updown_mode_in,
    input wire logic [7:0][15:0] gen_reg_in,
    input wire logic [7:0] capture_mode_in,
    input wire logic [7:0] capture_in,
    input wire logic [7:0] xfer_start_in,
    input wire logic xfer_disable_sel_in,
    output logic [7:0] match_capture_irq_out,
    output logic [2:0] overflow_irq_out,
    output logic [2:0] underflow_irq_out,
    output logic irq_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // which flag bits are real in which channel
    function automatic bit flag_exists(input int ch, input int b);
        flag_exists = 1'b0;
        case (b)
            tsc_pkg::FLD_A, tsc_pkg::FLD_B, tsc_pkg::FLD_OVF: flag_exists = 1'b1;
            tsc_pkg::FLD_C, tsc_pkg::FLD_D: flag_exists = (ch == 0);
            tsc_pkg::FLD_UDF: flag_exists = (ch == 1);
            default: flag_exists = 1'b0;
        endcase
    endfunction

    // general register slot behind a channel's match flag
    function automatic int gr_index(input int ch, input int b);
        case (ch)
            0: gr_index = b;
            1: gr_index = tsc_pkg::GR_BASE1 + b;
            default: gr_index = tsc_pkg::GR_BASE2 + b;
        endcase
    endfunction

    function automatic logic [7:0] exist_mask(input int ch);
        exist_mask = '0;
        for (int b = 0; b < 6; b++) begin
            exist_mask[b] = flag_exists(ch, b);
        end
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [2:0] stat_rd;
    logic [2:0] stat_wr;
    logic [2:0] cnt_wr;
    logic [2:0] ien_wr;

    always_comb begin
        for (int c = 0; c < 3; c++) begin
            stat_rd[c] = reg_rd_in && (reg_addr_in == tsc_pkg::OFS_STAT0 + 4'(c));
            stat_wr[c] = reg_wr_in && (reg_addr_in == tsc_pkg::OFS_STAT0 + 4'(c));
            cnt_wr[c] = reg_wr_in && (reg_addr_in == tsc_pkg::OFS_CNT0 + 4'(c));
            ien_wr[c] = reg_wr_in && (reg_addr_in == tsc_pkg::OFS_IEN0 + 4'(c));
        end
    end

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    logic [2:0][15:0] cnt;
    logic [2:0][15:0] cnt_nxt;
    logic [2:0] ovf_ev;
    logic [2:0] udf_ev;
    logic [2:0] dir_up;

    for (genvar c = 0; c < 3; c++) begin : g_ctr
        // a whole-word write is the only way software moves the counter
        tsc_chan_ctr #(
            .CNT_W(16),
            .UPDOWN(c != 0)
        ) u_ctr (
            .clock_in(clock_in),
            .rst_b_in(rst_b_in),
            .standby_in(standby_in),
            .tick_in(count_tick_in[c]),
            .down_in(count_down_in[c]),
            .updown_in(updown_mode_in[c]),
            .load_in(cnt_wr[c]),
            .load_val_in(reg_wdata_in),
            .count_out(cnt[c]),
            .count_nxt_out(cnt_nxt[c]),
            .ovf_out(ovf_ev[c]),
            .udf_out(udf_ev[c]),
            .dir_up_out(dir_up[c])
        );
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    logic [2:0][5:0] flag;
    logic [2:0][5:0] flag_set;
    logic xfer_ok;

    assign xfer_ok = !xfer_disable_sel_in;

    for (genvar c = 0; c < 3; c++) begin : g_ch
        for (genvar b = 0; b < 6; b++) begin : g_bit
            if (flag_exists(c, b)) begin : g_flag
                localparam int G = gr_index(c, b);
                logic set;
                logic dclr;
                if (b < 4) begin : g_match
                    // channels 1 and 2 flag b has no capture path
                    localparam bit CAP_OK = (c == 0) || (b != tsc_pkg::FLD_B);
                    logic cmp_hit;
                    logic cap_hit;
                    assign cmp_hit = !(capture_mode_in[G] && CAP_OK)
                        && count_tick_in[c] && !cnt_wr[c]
                        && (cnt_nxt[c] == gen_reg_in[G]);
                    assign cap_hit = CAP_OK && capture_mode_in[G]
                        && capture_in[G];
                    assign set = cmp_hit || cap_hit;
                    assign dclr = xfer_start_in[G] && xfer_ok;
                end else if (b == tsc_pkg::FLD_OVF) begin : g_ovf
                    assign set = ovf_ev[c];
                    assign dclr = 1'b0;
                end else begin : g_udf
                    assign set = udf_ev[c];
                    assign dclr = 1'b0;
                end
                assign flag_set[c][b] = set;
                tsc_status_flag u_flag (
                    .clock_in(clock_in),
                    .rst_b_in(rst_b_in),
                    .standby_in(standby_in),
                    .set_in(set),
                    .rd_hit_in(stat_rd[c]),
                    .wr_hit_in(stat_wr[c]),
                    .wr_bit_in(reg_wdata_in[b]),
                    .xfer_clr_in(dclr),
                    .flag_out(flag[c][b])
                );
            end else begin : g_none
                assign flag[c][b] = 1'b0;
                assign flag_set[c][b] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // status readback
    // ------------------------------------------------------------
    logic [2:0][7:0] stat;

    always_comb begin
        for (int c = 0; c < 3; c++) begin
            stat[c] = {2'b11, flag[c]};
            if (c != 0) begin
                stat[c][tsc_pkg::FLD_DIR] = dir_up[c];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt enables
    // ------------------------------------------------------------
    logic [2:0][7:0] ien_r;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ien_r <= {3{tsc_pkg::IEN_RST}};
        end else if (standby_in) begin
            ien_r <= {3{tsc_pkg::IEN_RST}};
        end else begin
            for (int c = 0; c < 3; c++) begin
                if (ien_wr[c]) begin
                    ien_r[c] <= reg_wdata_in[7:0] & exist_mask(c);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            overflow_irq_out[c] = flag[c][tsc_pkg::FLD_OVF]
                && ien_r[c][tsc_pkg::FLD_OVF];
            underflow_irq_out[c] = flag[c][tsc_pkg::FLD_UDF]
                && ien_r[c][tsc_pkg::FLD_UDF];
        end
        for (int b = 0; b < 4; b++) begin
            match_capture_irq_out[b] = flag[0][b] && ien_r[0][b];
        end
        for (int b = 0; b < 2; b++) begin
            match_capture_irq_out[tsc_pkg::GR_BASE1 + b] = flag[1][b] && ien_r[1][b];
            match_capture_irq_out[tsc_pkg::GR_BASE2 + b] = flag[2][b] && ien_r[2][b];
        end
    end

    assign irq_out = (|match_capture_irq_out) || (|overflow_irq_out)
        || (|underflow_irq_out);

    // ------------------------------------------------------------
    // read data, valid only in the cycle after the strobe
    // ------------------------------------------------------------
    logic [15:0] rdata_nxt;
    logic [15:0] rdata_r;

    always_comb begin
        rdata_nxt = '0;
        if (reg_rd_in) begin
            for (int c = 0; c < 3; c++) begin
                if (reg_addr_in == tsc_pkg::OFS_STAT0 + 4'(c)) begin
                    rdata_nxt = {8'h00, stat[c]};
                end
                if (reg_addr_in == tsc_pkg::OFS_CNT0 + 4'(c)) begin
                    rdata_nxt = cnt[c];
                end
                if (reg_addr_in == tsc_pkg::OFS_IEN0 + 4'(c)) begin
                    rdata_nxt = {8'h00, ien_r[c]};
                end
            end
        end
    end

    // cleared between reads so stale data never lingers on the bus
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);

    chk_status_init: assert property (
        standby_in |=> stat[0] == tsc_pkg::STAT_RST && stat[2] == tsc_pkg::STAT_RST)
        else $error("status not at reset value after standby");

    chk_write_one: assert property (
        stat_wr[0] && reg_wdata_in[tsc_pkg::FLD_OVF] && flag[0][tsc_pkg::FLD_OVF]
        && !standby_in |=> flag[0][tsc_pkg::FLD_OVF])
        else $error("writing one changed a flag");

    chk_dir_down: assert property (
        updown_mode_in[1] && count_down_in[1] |-> !stat[1][tsc_pkg::FLD_DIR])
        else $error("direction flag wrong while counting down");

    chk_fixed_bits: assert property (
        stat[0][7:5] == 3'b110 && stat[2][6:5] == 2'b10 && stat[1][6]
        && stat[1][3:2] == 2'b00)
        else $error("fixed status bits wrong");

    chk_underflow: assert property (
        udf_ev[1] && !standby_in |=> cnt[1] == 16'hffff && flag[1][tsc_pkg::FLD_UDF])
        else $error("underflow not flagged");

    chk_overflow: assert property (
        count_tick_in[0] && cnt[0] == 16'hffff && !cnt_wr[0] && !standby_in
        |=> cnt[0] == 16'h0000 && flag[0][tsc_pkg::FLD_OVF])
        else $error("overflow not flagged");

    chk_match_set: assert property (
        !capture_mode_in[4] && count_tick_in[1] && !cnt_wr[1] && !standby_in
        && cnt_nxt[1] == gen_reg_in[4] |=> flag[1][tsc_pkg::FLD_A])
        else $error("compare match did not set flag");

    chk_no_cap_b: assert property (
        capture_in[5] && !flag_set[1][tsc_pkg::FLD_B] && !flag[1][tsc_pkg::FLD_B]
        |=> !flag[1][tsc_pkg::FLD_B])
        else $error("channel 1 flag b set by capture");

    chk_irq_gate: assert property (
        irq_out |-> (|(flag[0] & ien_r[0][5:0])) || (|(flag[1] & ien_r[1][5:0]))
        || (|(flag[2] & ien_r[2][5:0])))
        else $error("interrupt without enabled flag");
endmodule

// ===== shared/tsc_pkg.sv
package tsc_pkg;
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int NUM_CH = 3;
    localparam int NUM_GR = 8;
    // word addresses; a channel's register sits at base + channel
    localparam logic [3:0] OFS_STAT0 = 4'h0;
    localparam logic [3:0] OFS_CNT0 = 4'h4;
    localparam logic [3:0] OFS_IEN0 = 4'h8;
    // ------------------------------------------------------------
    // status and enable field positions
    // ------------------------------------------------------------
    localparam int FLD_A = 0;
    localparam int FLD_B = 1;
    localparam int FLD_C = 2;
    localparam int FLD_D = 3;
    localparam int FLD_OVF = 4;
    localparam int FLD_UDF = 5;
    localparam int FLD_FIXED = 6;
    localparam int FLD_DIR = 7;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] STAT_RST = 8'hc0;
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    // base index of each channel's general registers in gen_reg_in
    localparam int GR_BASE1 = 4;
    localparam int GR_BASE2 = 6;
endpackage

// ===== hdl/tsc_status_flag.sv
module tsc_status_flag (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic standby_in,
    input wire logic set_in,
    input wire logic rd_hit_in,
    input wire logic wr_hit_in,
    input wire logic wr_bit_in,
    input wire logic xfer_clr_in,
    output logic flag_out
);
    logic flag_r;
    logic armed_r;
    logic clr;

    // a written zero only counts after the flag was seen as one
    assign clr = (wr_hit_in && !wr_bit_in && armed_r) || xfer_clr_in;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            armed_r <= 1'b0;
        end else if (standby_in || wr_hit_in) begin
            armed_r <= 1'b0;
        end else if (rd_hit_in && flag_r) begin
            armed_r <= 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flag_r <= 1'b0;
        end else if (standby_in) begin
            flag_r <= 1'b0;
        end else if (set_in) begin
            flag_r <= 1'b1;
        end else if (clr) begin
            flag_r <= 1'b0;
        end
    end

    assign flag_out = flag_r;

    chk_clear_gate: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $fell(flag_r) |-> $past(standby_in || xfer_clr_in
            || (armed_r && wr_hit_in && !wr_bit_in)))
        else $error("flag dropped without a qualified clear");

    chk_xfer_clear: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        xfer_clr_in && !set_in |=> !flag_r)
        else $error("transfer start did not clear flag");

    chk_set_wins: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        set_in && !standby_in |=> flag_r ##1 (flag_r || $past(clr) || $past(standby_in)))
        else $error("set lost against clear");
endmodule

// ===== hdl/tsc_chan_ctr.sv
module tsc_chan_ctr #(
    parameter int CNT_W = 16,
    parameter bit UPDOWN = 1'b1
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic standby_in,
    input wire logic tick_in,
    input wire logic down_in,
    input wire logic updown_in,
    input wire logic load_in,
    input wire logic [CNT_W-1:0] load_val_in,
    output logic [CNT_W-1:0] count_out,
    output logic [CNT_W-1:0] count_nxt_out,
    output logic ovf_out,
    output logic udf_out,
    output logic dir_up_out
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic dn;

    if (CNT_W != 16) begin : g_bad_width
        $error("counter width must be 16");
    end

    // a fixed up-counter ignores the direction inputs entirely
    assign dn = UPDOWN && updown_in && down_in;
    assign dir_up_out = !dn;

    always_comb begin
        count_nxt = count_r;
        if (load_in) begin
            count_nxt = load_val_in;
        end else if (tick_in && dn) begin
            count_nxt = count_r - 1'b1;
        end else if (tick_in) begin
            count_nxt = count_r + 1'b1;
        end
    end

    // a bus write takes the counter over, so it never flags a wrap
    assign ovf_out = tick_in && !load_in && !dn && (&count_r);
    assign udf_out = tick_in && !load_in && dn && (count_r == '0);

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_r <= tsc_pkg::CNT_RST;
        end else if (standby_in) begin
            count_r <= tsc_pkg::CNT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count_out = count_r;
    assign count_nxt_out = count_nxt;

    chk_count_step: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        tick_in && !load_in && !standby_in && !dn |=> count_r == $past(count_r) + 1'b1)
        else $error("counter did not step up");

    chk_count_init: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        standby_in |=> count_r == tsc_pkg::CNT_RST)
        else $error("counter not cleared by standby");
endmodule

// ===== sim/tsc_host_model.sv
module tsc_host_model (
    input wire logic clock_in,
    output logic [3:0] reg_addr_out,
    output logic [15:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [15:0] reg_rdata_in,
    output logic [7:0] xfer_start_out,
    output logic xfer_disable_sel_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    initial begin
        reg_addr_out = 4'h0;
        reg_wdata_out = 16'h5a5a;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        xfer_start_out = 8'h00;
        xfer_disable_sel_out = 1'b1;
    end
    // idle address and data keep changing so a stale value never looks valid
    always @(posedge clock_in) begin
        if (!busy) begin
            reg_addr_out <= ~reg_addr_out;
            reg_wdata_out <= ~reg_wdata_out;
        end
    end
    // every access is a whole 16-bit word
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        busy = 1'b1;
        @(posedge clock_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clock_in);
        reg_wr_out <= 1'b0;
        busy = 1'b0;
    endtask
    // a status read arms the later clearing write
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        busy = 1'b1;
        @(posedge clock_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clock_in);
        reg_rd_out <= 1'b0;
        @(posedge clock_in);
        d = reg_rdata_in;
        busy = 1'b0;
    endtask
    task automatic kick(input logic [7:0] m, input logic dis);
        @(posedge clock_in);
        xfer_start_out <= m;
        xfer_disable_sel_out <= dis;
        @(posedge clock_in);
        xfer_start_out <= 8'h00;
    endtask
endmodule

// ===== sim/timer_status_and_counters_tb.sv
module timer_status_and_counters_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic rst_b = 1'b0;
    logic standby = 1'b0;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic [2:0] tick_m = 3'h0;
    logic [2:0] down = 3'h0;
    logic [2:0] updn = 3'h0;
    logic [7:0][15:0] gr = {8{16'h8000}};
    logic [7:0] capm = 8'h00;
    logic [7:0] cap = 8'h00;
    logic [7:0] kick_m;
    logic xdis;
    logic [7:0] mc_irq;
    logic [2:0] ov_irq;
    logic [2:0] ud_irq;
    logic irq;
    logic [15:0] cnt [3];
    logic [5:0] flg [3];
    logic [5:0] arm [3];
    logic [5:0] ien [3];
    logic [5:0] msk [3] = '{6'h1f, 6'h33, 6'h13};
    logic [15:0] lf = 16'h002a;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #2 clock_in = ~clock_in;
    tsc_host_model u_host (.clock_in(clock_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata), .xfer_start_out(kick_m),
        .xfer_disable_sel_out(xdis));
    tsc_top u_dut (.clock_in(clock_in), .rst_b_in(rst_b), .standby_in(standby),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .count_tick_in(tick_m), .count_down_in(down),
        .updown_mode_in(updn), .gen_reg_in(gr), .capture_mode_in(capm), .capture_in(cap),
        .xfer_start_in(kick_m), .xfer_disable_sel_in(xdis), .match_capture_irq_out(mc_irq),
        .overflow_irq_out(ov_irq), .underflow_irq_out(ud_irq), .irq_out(irq));
    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int chan(input int k);
        return k < 4 ? 0 : (k < 6 ? 1 : 2);
    endfunction
    function automatic int bp(input int k);
        return k < 4 ? k : k % 2;
    endfunction
    // flag b of channels 1 and 2 never captures
    function automatic logic capeff(input int k);
        return capm[k] && k != 5 && k != 7;
    endfunction
    function automatic logic [15:0] exp_rd(input int a);
        int c;
        c = a % 4;
        if (c == 3 || a > 10) return 16'h0000;
        if (a < 4) return {8'h00, c == 0 || !(updn[c] && down[c]), 1'b1, flg[c]};
        if (a < 8) return cnt[c];
        return {10'h000, ien[c]};
    endfunction
    task automatic mreset;
        for (int c = 0; c < 3; c++) begin
            cnt[c] = 16'h0000;
            flg[c] = 6'h00;
            arm[c] = 6'h00;
            ien[c] = 6'h00;
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bwr(input int a, input logic [15:0] d);
        u_host.wr(a[3:0], d);
        if (a < 3) begin
            flg[a] = flg[a] & ~(arm[a] & ~d[5:0]);
            arm[a] = 6'h00;
        end else if (a > 3 && a < 7) begin
            cnt[a - 4] = d;
        end else if (a > 7 && a < 11) begin
            ien[a - 8] = d[5:0] & msk[a - 8];
        end
    endtask
    task automatic brd(input int a);
        logic [15:0] e;
        logic [15:0] d;
        e = exp_rd(a);
        u_host.rd(a[3:0], d);
        chk({16'h0000, d}, {16'h0000, e});
        if (a < 3) arm[a] = arm[a] | flg[a];
    endtask
    task automatic tick(input logic [2:0] m);
        logic [15:0] nx;
        logic dn;
        @(posedge clock_in);
        tick_m <= m;
        @(posedge clock_in);
        tick_m <= 3'h0;
        for (int c = 0; c < 3; c++) begin
            if (m[c]) begin
                dn = c != 0 && updn[c] && down[c];
                nx = dn ? cnt[c] - 16'h0001 : cnt[c] + 16'h0001;
                if (!dn && cnt[c] == 16'hffff) flg[c][4] = 1'b1;
                if (dn && cnt[c] == 16'h0000 && c == 1) flg[c][5] = 1'b1;
                for (int k = 0; k < 8; k++) begin
                    if (chan(k) == c && !capeff(k) && gr[k] == nx) flg[c][bp(k)] = 1'b1;
                end
                cnt[c] = nx;
            end
        end
    endtask
    task automatic kick(input logic [7:0] m, input logic dis);
        u_host.kick(m, dis);
        for (int k = 0; k < 8; k++) begin
            if (m[k] && !dis) flg[chan(k)][bp(k)] = 1'b0;
        end
    endtask
    task automatic chk_irq;
        logic [13:0] e;
        #1;
        for (int k = 0; k < 8; k++) e[k + 6] = flg[chan(k)][bp(k)] & ien[chan(k)][bp(k)];
        for (int c = 0; c < 3; c++) begin
            e[c + 3] = flg[c][4] & ien[c][4];
            e[c] = flg[c][5] & ien[c][5];
        end
        chk({18'h0, mc_irq, ov_irq, ud_irq}, {18'h0, e});
        chk({31'h0, irq}, {31'h0, |e});
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // a hang counts as a mismatch; the whole run needs well under this
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            stop_test;
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        mreset;
        repeat (10) @(posedge clock_in);
        rst_b <= 1'b1;
        for (int a = 0; a < 16; a++) brd(a);
        chk_irq;
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            lf = lfsr(lf);
            bwr(4 + i % 3, lf);
            brd(4 + i % 3);
        end
        $display("test counter load done");
        for (int c = 0; c < 3; c++) begin
            bwr(8 + c, 16'hffff);
            bwr(4 + c, 16'hffff);
        end
        tick(3'h7);
        for (int a = 0; a < 11; a++) brd(a);
        chk_irq;
        $display("test overflow done");
        bwr(0, 16'hffff);
        bwr(0, 16'h0000);
        brd(0);
        bwr(0, 16'h0000);
        brd(0);
        chk_irq;
        $display("test clearing done");
        updn <= 3'h7;
        down <= 3'h7;
        for (int c = 0; c < 3; c++) bwr(4 + c, 16'h0000);
        tick(3'h7);
        for (int a = 0; a < 7; a++) brd(a);
        chk_irq;
        updn <= 3'h5;
        tick(3'h2);
        brd(1);
        brd(5);
        updn <= 3'h0;
        down <= 3'h0;
        $display("test direction done");
        gr[0] <= 16'h0005;
        gr[4] <= 16'h0003;
        gr[5] <= 16'h0003;
        capm <= 8'h24;
        bwr(4, 16'h0004);
        bwr(5, 16'h0002);
        @(posedge clock_in);
        cap <= 8'h25;
        @(posedge clock_in);
        cap <= 8'h00;
        flg[0][2] = 1'b1;
        brd(0);
        brd(1);
        tick(3'h3);
        brd(0);
        brd(1);
        for (int c = 0; c < 3; c++) bwr(8 + c, 16'h0000);
        chk_irq;
        bwr(8, 16'h0001);
        chk_irq;
        $display("test match capture done");
        kick(8'h01, 1'b1);
        brd(0);
        kick(8'hff, 1'b0);
        for (int a = 0; a < 3; a++) brd(a);
        $display("test transfer clear done");
        bwr(4, 16'hffff);
        tick(3'h1);
        brd(0);
        bwr(4, 16'hffff);
        fork
            u_host.wr(4'h0, 16'h0000);
            tick(3'h1);
        join
        arm[0] = 6'h00;
        brd(0);
        $display("test set priority done");
        bwr(9, 16'h0033);
        @(posedge clock_in);
        standby <= 1'b1;
        @(posedge clock_in);
        standby <= 1'b0;
        mreset;
        for (int a = 0; a < 11; a++) brd(a);
        chk_irq;
        $display("test standby done");
        stop_test;
    end
endmodule
